// >>> logic/cie_pkg.sv
package cie_pkg;

    // =========================================================
    // timing
    // =========================================================
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned ENTRY_CYCLES   = 4;
    localparam int unsigned WAKE_CYCLES    = 4;
    localparam int unsigned JUMP_CYCLES    = 3;
    localparam int unsigned RETURN_CYCLES  = 4;
    localparam int unsigned BOOT_CYCLES    = 3;
    localparam int unsigned CNT_W          = 3;

    // =========================================================
    // register map (byte addresses)
    // =========================================================
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_ENABLE     = 8'h04;
    localparam logic [7:0] ADDR_FLAGS      = 8'h08;
    localparam logic [7:0] ADDR_STATUS     = 8'h0c;
    localparam logic [7:0] ADDR_PUSHED     = 8'h10;

    localparam int unsigned CTRL_RELOC_BIT = 0;
    localparam int unsigned STAT_GIE_BIT   = 0;
    localparam int unsigned STAT_HOLD_BIT  = 1;
    localparam int unsigned STAT_BUSY_BIT  = 2;
    localparam int unsigned STAT_WIN_LSB   = 8;
    localparam int unsigned STAT_LOCK_BIT  = 16;

    localparam logic        RST_RELOC      = 1'b0;
    localparam logic        RST_GIE        = 1'b0;
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic        HRESP_OKAY     = 1'b0;

    // =========================================================
    // types
    // =========================================================
    localparam int unsigned PC_W = 16;

    typedef enum logic [2:0] {
        CIE_BOOT,
        CIE_RUN,
        CIE_WAKE,
        CIE_ENTRY,
        CIE_JUMP,
        CIE_RETURN
    } cie_state_t;

    // sequencer to controller
    typedef struct packed {
        logic            instr_done;
        logic            sei;
        logic            global_disable_instr;
        logic            return_from_handler;
        logic            sleeping;
        logic [PC_W-1:0] next_pc;
    } cie_seq_t;

    // controller to stack
    typedef struct packed {
        logic       push;
        logic       pop;
        logic       sp_inc2;
        logic [7:0] wdata;
    } cie_stack_t;

endpackage

// >>> logic/cie_top.sv
`timescale 1ns/100ps

// Summary of operation
// - each source has its own vector; lower vector address wins priority
// - reset is top priority, external_request_zero (source 0) next
// - dispatch needs both the source enable and global enable
// - entering any handler clears the global enable
// - software may set global enable in a handler to allow nesting
// - return_from_handler sets the global enable again
// - flag sources have their flag cleared by hardware on vectoring
// - writing one to a flag clears it, zero leaves it
// - flag events while disabled are held until enabled or cleared
// - flags held while globally disabled are served later by priority
// - level sources request only while their condition is present
// - one program instruction runs after return before the next dispatch
// - status flags are never saved or restored by this logic
// - global_disable_instr blocks dispatch at once, same cycle included
// - after global enable the next instruction runs before dispatch
// - entry takes four cycles while the program counter is pushed
// - the vector jump takes three cycles
// - a multi-cycle instruction finishes before entry begins
// - wake from sleep adds four cycles to the entry
// - return takes four cycles, pops two bytes, stack pointer plus two
// - vector_relocate_sel moves vectors, boot_reset_fuse the reset vector
// - lock bits suppress dispatch depending on the current pc section
module cie_top #(
    parameter int unsigned             NSRC       = 8,
    parameter logic [NSRC-1:0]         LEVEL_MASK = '0,
    parameter logic [cie_pkg::PC_W-1:0] BOOT_START = 16'h1000,
    parameter int unsigned             VEC_WORDS  = 2
) (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    // ahb-lite slave
    input  wire logic                       i_hsel,
    input  wire logic [31:0]                i_haddr,
    input  wire logic [1:0]                 i_htrans,
    input  wire logic                       i_hwrite,
    input  wire logic [2:0]                 i_hsize,
    input  wire logic [31:0]                i_hwdata,
    input  wire logic                       i_hready,
    output logic      [31:0]                o_hrdata,
    output logic                            o_hreadyout,
    output logic                            o_hresp,
    // interrupt sources
    input  wire logic [NSRC-1:0]            i_src_cond,
    // fuse and lock pins
    input  wire logic                       i_boot_reset_fuse,
    input  wire logic                       i_app_lock_bit_b,
    input  wire logic                       i_boot_lock_bit_b,
    // instruction sequencer
    input  wire cie_pkg::cie_seq_t          i_seq,
    output logic                            o_busy,
    output logic                            o_pc_load,
    output logic      [cie_pkg::PC_W-1:0]   o_pc_value,
    output logic                            o_gie,
    output logic                            o_wake,
    // stack
    output cie_pkg::cie_stack_t             o_stack,
    input  wire logic [7:0]                 i_stack_rdata
);
    import cie_pkg::*;

    localparam int unsigned IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;

    // =========================================================
    // functions
    // =========================================================
    // lowest index wins: lower vector address means higher priority
    function automatic logic [IDX_W-1:0] pick(input logic [NSRC-1:0] r);
        logic [IDX_W-1:0] p;
        p = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (r[i]) begin
                p = IDX_W'(i);
            end
        end
        return p;
    endfunction

    // source k sits k+1 vector slots above reset
    function automatic logic [PC_W-1:0] vec_addr(
        input logic             rel,
        input logic [IDX_W-1:0] idx
    );
        logic [PC_W-1:0] base;
        base = rel ? BOOT_START : '0;
        return base + PC_W'((idx + 1) * VEC_WORDS);
    endfunction

    // =========================================================
    // pin synchronisers
    // =========================================================
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {i_boot_lock_bit_b, i_app_lock_bit_b,
                         i_boot_reset_fuse};
            pin_sync <= pin_meta;
        end
    end

    logic fuse_boot_rst;
    logic app_lock;
    logic boot_lock;
    assign fuse_boot_rst = pin_sync[0];
    assign app_lock      = pin_sync[1];
    assign boot_lock     = pin_sync[2];

    // =========================================================
    // state
    // =========================================================
    cie_state_t        state;
    cie_state_t        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              gie;
    logic              next_gie;
    logic              hold;
    logic              next_hold;
    logic              reloc;
    logic              next_reloc;
    logic [NSRC-1:0]   enable;
    logic [NSRC-1:0]   next_enable;
    logic [NSRC-1:0]   flags;
    logic [NSRC-1:0]   next_flags;
    logic [IDX_W-1:0]  win;
    logic [IDX_W-1:0]  next_win;
    logic [PC_W-1:0]   pushed;
    logic [PC_W-1:0]   next_pushed;
    logic [7:0]        ret_hi;
    logic [7:0]        next_ret_hi;
    logic              next_pc_load;
    logic [PC_W-1:0]   next_pc_value;
    logic              next_wake;
    logic              next_busy;
    cie_stack_t        next_stack;

    // bus data phase
    logic              dp_we;
    logic [7:0]        dp_addr;
    logic              next_dp_we;
    logic [7:0]        next_dp_addr;
    logic [31:0]       next_hrdata;

    // =========================================================
    // request logic
    // =========================================================
    logic [NSRC-1:0] req;
    logic            pc_in_boot;
    logic            suppress;
    logic            can_take;

    // flag sources request from the latched flag, level sources live
    assign req = ((flags & ~LEVEL_MASK) | (i_src_cond & LEVEL_MASK))
               & enable;

    assign pc_in_boot = (i_seq.next_pc >= BOOT_START);
    assign suppress   = (app_lock & ~pc_in_boot & reloc)
                      | (boot_lock & pc_in_boot & ~reloc);

    // cli in the same cycle kills the request as well
    assign can_take = gie & ~i_seq.global_disable_instr & ~hold & (|req)
                    & ~suppress;

    // =========================================================
    // sequencer state machine and interrupt registers
    // =========================================================
    always_comb begin
        logic [NSRC-1:0] clr;
        clr           = '0;
        next_state    = state;
        next_cnt      = cnt;
        next_gie      = gie;
        next_hold     = hold;
        next_reloc    = reloc;
        next_enable   = enable;
        next_win      = win;
        next_pushed   = pushed;
        next_ret_hi   = ret_hi;
        next_pc_load  = 1'b0;
        next_pc_value = o_pc_value;
        next_wake     = 1'b0;
        next_stack    = '0;

        if (dp_we) begin
            if (dp_addr == ADDR_CTRL) begin
                next_reloc = i_hwdata[CTRL_RELOC_BIT];
            end else if (dp_addr == ADDR_ENABLE) begin
                next_enable = i_hwdata[NSRC-1:0];
            end else if (dp_addr == ADDR_FLAGS) begin
                clr = i_hwdata[NSRC-1:0];
            end
        end

        // global enable commands; disabling wins at once
        if (i_seq.sei) begin
            next_gie = 1'b1;
            if (!gie) begin
                next_hold = 1'b1;
            end
        end else if (i_seq.instr_done) begin
            next_hold = 1'b0;
        end
        if (i_seq.global_disable_instr) begin
            next_gie = 1'b0;
        end

        case (state)
            CIE_BOOT: begin
                // let the fuse synchroniser settle before loading
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(BOOT_CYCLES - 1)) begin
                    next_cnt      = '0;
                    next_pc_load  = 1'b1;
                    next_pc_value = fuse_boot_rst ? BOOT_START
                                                  : '0;
                    next_state    = CIE_RUN;
                end
            end
            CIE_RUN: begin
                if (i_seq.return_from_handler) begin
                    next_state = CIE_RETURN;
                    next_cnt   = '0;
                end else if (i_seq.instr_done && can_take) begin
                    // only at an instruction boundary
                    next_state  = CIE_ENTRY;
                    next_cnt    = '0;
                    next_win    = pick(req);
                    next_pushed = i_seq.next_pc;
                    next_gie    = 1'b0;
                    clr[pick(req)] = ~LEVEL_MASK[pick(req)];
                end else if (i_seq.sleeping && can_take) begin
                    next_state  = CIE_WAKE;
                    next_cnt    = '0;
                    next_wake   = 1'b1;
                    next_win    = pick(req);
                    next_pushed = i_seq.next_pc;
                    next_gie    = 1'b0;
                    clr[pick(req)] = ~LEVEL_MASK[pick(req)];
                end
            end
            CIE_WAKE: begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(WAKE_CYCLES - 1)) begin
                    next_state = CIE_ENTRY;
                    next_cnt   = '0;
                end
            end
            CIE_ENTRY: begin
                next_cnt = cnt + 1'b1;
                if (cnt == 0) begin
                    next_stack.push  = 1'b1;
                    next_stack.wdata = pushed[7:0];
                end else if (cnt == 1) begin
                    next_stack.push  = 1'b1;
                    next_stack.wdata = pushed[15:8];
                end
                if (cnt == CNT_W'(ENTRY_CYCLES - 1)) begin
                    next_state    = CIE_JUMP;
                    next_cnt      = '0;
                    next_pc_load  = 1'b1;
                    next_pc_value = vec_addr(reloc, win);
                end
            end
            CIE_JUMP: begin
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(JUMP_CYCLES - 1)) begin
                    next_state = CIE_RUN;
                    next_cnt   = '0;
                end
            end
            CIE_RETURN: begin
                // pop strobe is registered: data arrives two cycles on
                next_cnt = cnt + 1'b1;
                if (cnt < 2) begin
                    next_stack.pop = 1'b1;
                end
                if (cnt == 2) begin
                    next_ret_hi = i_stack_rdata;
                end
                if (cnt == CNT_W'(RETURN_CYCLES - 1)) begin
                    next_state         = CIE_RUN;
                    next_cnt           = '0;
                    next_pc_load       = 1'b1;
                    next_pc_value      = {ret_hi, i_stack_rdata};
                    next_stack.sp_inc2 = 1'b1;
                    next_gie           = 1'b1;
                    next_hold          = 1'b1;
                end
            end
            default: begin
                next_state = CIE_RUN;
                next_cnt   = '0;
            end
        endcase

        // status flags of the core are left alone: handlers save them
        // a new event wins over either kind of clear
        next_flags = (flags & ~clr)
                   | (i_src_cond & ~LEVEL_MASK);
        next_busy  = (next_state != CIE_RUN);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state      <= CIE_BOOT;
            cnt        <= '0;
            gie        <= RST_GIE;
            hold       <= 1'b0;
            reloc      <= RST_RELOC;
            enable     <= '0;
            flags      <= '0;
            win        <= '0;
            pushed     <= '0;
            ret_hi     <= '0;
            o_pc_load  <= 1'b0;
            o_pc_value <= '0;
            o_wake     <= 1'b0;
            o_busy     <= 1'b1;
            o_gie      <= RST_GIE;
            o_stack    <= '0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            gie        <= next_gie;
            hold       <= next_hold;
            reloc      <= next_reloc;
            enable     <= next_enable;
            flags      <= next_flags;
            win        <= next_win;
            pushed     <= next_pushed;
            ret_hi     <= next_ret_hi;
            o_pc_load  <= next_pc_load;
            o_pc_value <= next_pc_value;
            o_wake     <= next_wake;
            o_busy     <= next_busy;
            o_gie      <= next_gie;
            o_stack    <= next_stack;
        end
    end

    // =========================================================
    // ahb-lite slave
    // =========================================================
    // zero wait states; reads are sampled at the address phase
    always_comb begin
        logic [31:0] rd;
        rd           = '0;
        next_dp_we   = 1'b0;
        next_dp_addr = dp_addr;
        next_hrdata  = o_hrdata;
        if (i_hready && i_hsel && (i_htrans == HTRANS_NONSEQ)) begin
            next_dp_we   = i_hwrite;
            next_dp_addr = i_haddr[7:0];
            if (i_haddr[31:8] != '0) begin
                rd = '0;
            end else if (i_haddr[7:0] == ADDR_CTRL) begin
                rd[CTRL_RELOC_BIT] = reloc;
            end else if (i_haddr[7:0] == ADDR_ENABLE) begin
                rd[NSRC-1:0] = enable;
            end else if (i_haddr[7:0] == ADDR_FLAGS) begin
                rd[NSRC-1:0] = flags;
            end else if (i_haddr[7:0] == ADDR_STATUS) begin
                rd[STAT_GIE_BIT]                  = gie;
                rd[STAT_HOLD_BIT]                 = hold;
                rd[STAT_BUSY_BIT]                 = o_busy;
                rd[STAT_WIN_LSB +: IDX_W]         = win;
                rd[STAT_LOCK_BIT]                 = suppress;
            end else if (i_haddr[7:0] == ADDR_PUSHED) begin
                rd[PC_W-1:0] = pushed;
            end
            next_hrdata = i_hwrite ? o_hrdata : rd;
            if (i_haddr[31:8] != '0) begin
                next_dp_we = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dp_we       <= 1'b0;
            dp_addr     <= '0;
            o_hrdata    <= '0;
            o_hreadyout <= 1'b1;
            o_hresp     <= HRESP_OKAY;
        end else begin
            dp_we       <= next_dp_we;
            dp_addr     <= next_dp_addr;
            o_hrdata    <= next_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp     <= HRESP_OKAY;
        end
    end

    // hsize is not checked: only whole-word accesses are expected
    logic unused_hsize;
    assign unused_hsize = ^i_hsize;

endmodule // cie_top

// >>> tb/cie_checker.sv
`timescale 1ns/100ps
module cie_checker
    import cie_pkg::*;
#(
    parameter logic [PC_W-1:0] BOOT_START = 16'h1000
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // watched ports
    input  wire logic              i_boot_reset_fuse,
    input  wire cie_seq_t          i_seq,
    input  wire logic              o_busy,
    input  wire logic              o_pc_load,
    input  wire logic [PC_W-1:0]   o_pc_value,
    input  wire logic              o_gie,
    input  wire logic              o_wake,
    input  wire cie_stack_t        o_stack
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // =========================================================
    // entry and return
    // =========================================================
    a_entry_steps: assert property (
        $rose(o_busy) && $past(i_seq.instr_done) && !$past(i_seq.return_from_handler)
        |-> !o_gie ##1 o_stack.push ##1 o_stack.push ##1 !o_pc_load
        ##1 o_pc_load ##1 o_busy [*2] ##1 !o_busy)
        else $error("entry sequence out of step");
    a_push_bytes: assert property (
        $rose(o_busy) && $past(i_seq.instr_done) && !$past(i_seq.return_from_handler)
        |-> ##1 ({8'h00, o_stack.wdata} == ($past(i_seq.next_pc, 2) & 16'h00ff))
        ##1 ({o_stack.wdata, 8'h00} == ($past(i_seq.next_pc, 3) & 16'hff00)))
        else $error("pushed bytes differ from next pc");
    a_return_steps: assert property (
        !o_busy && i_seq.return_from_handler |=> o_busy ##[0:1] o_stack.pop ##1 o_stack.pop
        ##[1:2] (o_pc_load && o_stack.sp_inc2 && o_gie))
        else $error("return sequence out of step");
    a_boot_vector: assert property (
        $rose(i_rst_n) |-> ##[2:4] (o_pc_load && o_pc_value ==
        (i_boot_reset_fuse ? BOOT_START : 16'h0000)))
        else $error("reset vector wrong or late");

    // =========================================================
    // dispatch gating
    // =========================================================
    a_dispatch_gate: assert property (
        $rose(o_busy) && !$past(i_seq.return_from_handler) |-> $past(o_gie) &&
        ($past(i_seq.instr_done) || $past(i_seq.sleeping)))
        else $error("dispatch without enable or mid instruction");
    a_cli_blocks: assert property (
        !o_busy && i_seq.global_disable_instr |=> !o_busy && !o_gie)
        else $error("dispatch taken with global disable");
    a_sei_defers: assert property (
        !o_busy && !o_gie && i_seq.sei |=> !o_busy && o_gie)
        else $error("dispatch before next instruction");
    a_wake_delay: assert property (
        $rose(o_wake) |-> !o_stack.push [*5] ##1 o_stack.push)
        else $error("wake entry delay wrong");
endmodule // cie_checker

bind cie_top cie_checker #(.BOOT_START(BOOT_START)) u_checker (
    .i_clk, .i_rst_n, .i_boot_reset_fuse, .i_seq, .o_busy, .o_pc_load,
    .o_pc_value, .o_gie, .o_wake, .o_stack
);

// >>> tb/cie_stack_model.sv
`timescale 1ns/100ps
module cie_stack_model
    import cie_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // stack port
    input  wire cie_stack_t  i_stack,
    output logic       [7:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] sp;
    logic [7:0] nth;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sp <= 8'hff;
            nth <= 8'h01;
            o_rdata <= 8'h00;
        end else begin
            // stale byte flips so a late sample never looks right
            o_rdata <= ~o_rdata;
            if (i_stack.push) begin
                mem[sp] <= i_stack.wdata;
                sp <= sp - 8'h01;
            end
            if (i_stack.pop) begin
                o_rdata <= mem[sp + nth];
                nth <= nth + 8'h01;
            end
            if (i_stack.sp_inc2) begin
                sp <= sp + 8'h02;
                nth <= 8'h01;
            end
        end
    end
endmodule // cie_stack_model

// >>> tb/cie_top_tb.sv
`timescale 1ns/100ps
module cie_top_tb;
    import cie_pkg::*;
    localparam logic [15:0] BOOT = 16'h1000;

    logic        i_clk, i_rst_n, i_hsel, i_hwrite, i_boot_reset_fuse;
    logic        i_app_lock_bit_b, o_hreadyout, o_hresp, o_busy, o_gie;
    logic        o_pc_load, o_wake, i_boot_lock_bit_b;
    logic [1:0]  i_htrans;
    logic [7:0]  i_src_cond, i_stack_rdata;
    logic [15:0] o_pc_value, pc, exp_pc, first_pc;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
    cie_seq_t    i_seq;
    cie_stack_t  o_stack;
    int          errors, n_tests;

    cie_top #(.LEVEL_MASK(8'h80), .BOOT_START(BOOT)) uut (
        .i_clk, .i_rst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
        .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
        .o_hreadyout, .o_hresp, .i_src_cond, .i_boot_reset_fuse,
        .i_app_lock_bit_b, .i_boot_lock_bit_b, .i_seq, .o_busy,
        .o_pc_load, .o_pc_value, .o_gie, .o_wake, .o_stack, .i_stack_rdata
    );
    cie_stack_model u_stack (
        .i_clk, .i_rst_n, .i_stack(o_stack), .o_rdata(i_stack_rdata)
    );

    // =========================================================
    // tasks
    // =========================================================
    task end_sim;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task fail;
        errors++;
        end_sim;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        int n;
        @(posedge i_clk);
        for (n = 0; o_hreadyout !== 1'b1; n++) begin
            if (n == 20) fail;
            @(posedge i_clk);
        end
    endtask
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_haddr <= {24'h0, a};
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= wr;
        wait_rdy;
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        wait_rdy;
        rd = o_hrdata;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, o_hresp}, {31'h0, HRESP_OKAY});
    endtask
    // f = {instr_done, sei, cli, return_from_handler, sleeping}; sleeping stays as set
    task drive(input logic [4:0] f);
        i_seq <= cie_seq_t'({f, pc});
        @(posedge i_clk);
        i_seq <= cie_seq_t'({4'h0, f[0], pc});
        @(posedge i_clk);
    endtask
    task setcond(input logic [7:0] c);
        i_src_cond <= c;
        @(posedge i_clk);
        i_src_cond <= 8'h00;
        @(posedge i_clk);
    endtask
    task wait_load;
        int n;
        for (n = 0; o_pc_load !== 1'b1; n++) begin
            if (n == 40) fail;
            @(posedge i_clk);
        end
    endtask
    task wait_idle;
        int n;
        for (n = 0; o_busy !== 1'b0; n++) begin
            if (n == 40) fail;
            @(posedge i_clk);
        end
    endtask
    // run instructions until a dispatch, then check the vector
    task go(input logic [15:0] vec);
        int n;
        for (n = 0; o_busy !== 1'b1; n++) begin
            if (n == 8) fail;
            pc = pc + 16'h1;
            exp_pc = pc;
            drive(5'b10000);
        end
        wait_load;
        chk({16'h0, o_pc_value}, {16'h0, vec});
        wait_idle;
    endtask
    task ret(input logic [15:0] exp);
        drive(5'b00010);
        wait_load;
        chk({16'h0, o_pc_value}, {16'h0, exp});
        chk({31'h0, o_gie}, 32'h1);
        wait_idle;
    endtask

    // =========================================================
    // stimulus
    // =========================================================
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, i_hsel, i_hwrite, i_boot_reset_fuse, i_app_lock_bit_b} = '0;
        {i_htrans, i_src_cond, i_haddr, i_hwdata, i_seq} = '0;
        {errors, n_tests, pc} = '0;
        i_boot_lock_bit_b = 1'b0;
        pc = 16'h0100;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wait_load;
        chk({16'h0, o_pc_value}, 32'h0);
        wait_idle;
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_ENABLE, 32'h0);
        rd_chk(8'h14, 32'h0);
        setcond(8'h28);
        rd_chk(ADDR_FLAGS, 32'h28);
        ahb(1'b1, ADDR_FLAGS, 32'h08);
        rd_chk(ADDR_FLAGS, 32'h20);
        ahb(1'b1, ADDR_FLAGS, 32'h0);
        rd_chk(ADDR_FLAGS, 32'h20);
        setcond(8'h08);
        ahb(1'b1, ADDR_ENABLE, 32'hff);
        drive(5'b10000);
        chk({31'h0, o_busy}, 32'h0);
        drive(5'b01000);
        drive(5'b10000);
        chk({31'h0, o_busy}, 32'h0);
        go(16'h0008);
        chk({31'h0, o_gie}, 32'h0);
        rd_chk(ADDR_FLAGS, 32'h20);
        rd_chk(ADDR_PUSHED, {16'h0, exp_pc});
        first_pc = exp_pc;
        drive(5'b01000);
        go(16'h000c);
        ret(exp_pc);
        ret(first_pc);
        setcond(8'h01);
        drive(5'b10000);
        chk({31'h0, o_busy}, 32'h0);
        drive(5'b10100);
        chk({31'h0, o_busy}, 32'h0);
        drive(5'b01000);
        go(16'h0002);
        ret(exp_pc);
        drive(5'b00100);
        setcond(8'h80);
        drive(5'b01000);
        repeat (2) drive(5'b10000);
        chk({31'h0, o_busy}, 32'h0);
        i_src_cond <= 8'h80;
        go(16'h0010);
        i_src_cond <= 8'h00;
        ret(exp_pc);
        ahb(1'b1, ADDR_CTRL, 32'h1);
        i_app_lock_bit_b <= 1'b1;
        setcond(8'h02);
        repeat (3) begin
            drive(5'b10000);
            chk({31'h0, o_busy}, 32'h0);
        end
        i_app_lock_bit_b <= 1'b0;
        go(BOOT + 16'h0004);
        ret(exp_pc);
        ahb(1'b1, ADDR_CTRL, 32'h0);
        i_boot_lock_bit_b <= 1'b1;
        pc = BOOT;
        setcond(8'h04);
        repeat (3) begin
            drive(5'b10000);
            chk({31'h0, o_busy}, 32'h0);
        end
        i_boot_lock_bit_b <= 1'b0;
        ahb(1'b1, ADDR_FLAGS, 32'h04);
        rd_chk(ADDR_FLAGS, 32'h0);
        // the sleep instruction itself completes, then the core sleeps
        drive(5'b10001);
        setcond(8'h10);
        wait_load;
        chk({16'h0, o_pc_value}, 32'h000a);
        wait_idle;
        ret(pc);
        i_boot_reset_fuse <= 1'b1;
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wait_load;
        chk({16'h0, o_pc_value}, {16'h0, BOOT});
        end_sim;
    end
endmodule // cie_top_tb
